// file: rtl/ssp_port.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defs.svh"
module ssp_port
   import ssp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [9:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        timerTick,
   input  wire logic        coreSleep,
   output logic             wakeReq,
   ssp_link_if.dev          lnk
);
   logic        wrColl;
   logic        rxOvf;
   logic        bufFull;
   logic [5:0]  cfg;
   logic [7:0]  intCtl;
   logic [7:0]  irqFlags;
   logic [7:0]  irqEn;
   logic [7:0]  dirC;
   logic [5:0]  dirA;
   logic [7:0]  serialBuffer;
   logic [7:0]  shiftReg;
   logic [2:0]  syn1;
   logic [2:0]  syn2;
   logic [2:0]  syn3;
   logic [2:0]  pinF;
   logic        sckPrev;
   logic        sckInt;
   logic        outBit;
   logic [3:0]  bitCnt;
   logic [5:0]  divCnt;
   ssp_state_t  state;
   logic [7:0]  regIdx;
   logic        acc;
   logic        wrAcc;
   logic        rdAcc;
   logic        mapped;
   logic [7:0]  rdVal;
   logic        portEn;
   logic        ckPol;
   logic        master;
   logic        slave;
   logic        gateOn;
   logic        ssOk;
   logic        dataInBit;
   logic        mEdge;
   logic        lead;
   logic        trail;
   logic        done;
   logic        busy;
   logic        bufWr;
   logic        bufRd;
   logic        keepRx;
   logic [7:0]  rxByte;

   function automatic logic isMaster(input logic [3:0] m);
      return m[3:2] == 2'b00;
   endfunction

   function automatic logic isSlave(input logic [3:0] m);
      return (m == `SSP_MODE_SLV_SEL) | (m == `SSP_MODE_SLV);
   endfunction

   function automatic logic [5:0] halfOf(input logic [3:0] m);
      case (m[1:0])
         2'b00:   return `SSP_HALF_DIV4;
         2'b01:   return `SSP_HALF_DIV16;
         default: return `SSP_HALF_DIV64;
      endcase
   endfunction

   // Mode decode; I2C encodings leave the port idle
   assign portEn = cfg[`SSP_BIT_EN];
   assign ckPol  = cfg[`SSP_BIT_CKPOL];
   assign master = portEn & isMaster(cfg[3:0]);
   assign slave  = portEn & isSlave(cfg[3:0]);
   assign gateOn = (cfg[3:0] == `SSP_MODE_SLV_SEL)
                   & dirA[`SSP_BIT_SEL_DIR];
   assign ssOk   = ~gateOn | ~pinF[1];
   assign dataInBit = dirC[`SSP_BIT_DIN_DIR] & pinF[0];

   assign mEdge = master & (state == ST_SHIFT) & ~coreSleep
                  & ((cfg[3:0] == `SSP_MODE_TIMER) ? timerTick
                     : (divCnt == halfOf(cfg[3:0]) - 6'h01));
   assign lead  = master ? (mEdge & (sckInt == ckPol))
                         : (slave & ssOk & (pinF[2] != sckPrev)
                            & (pinF[2] != ckPol));
   assign trail = master ? (mEdge & (sckInt != ckPol))
                         : (slave & ssOk & (pinF[2] != sckPrev)
                            & (pinF[2] == ckPol));
   assign done   = trail & (bitCnt == 4'h7);
   assign rxByte = {shiftReg[6:0], dataInBit};
   assign busy   = ((state == ST_SHIFT) & master)
                   | (slave & (bitCnt != 4'h0));
   assign keepRx = ~(slave & bufFull);

   assign regIdx = paddr[9:2];
   assign acc    = psel & penable & pready;
   assign wrAcc  = acc & pwrite & mapped;
   assign rdAcc  = acc & ~pwrite & mapped;
   assign bufWr  = wrAcc & (regIdx == `SSP_IDX_BUFFER);
   assign bufRd  = rdAcc & (regIdx == `SSP_IDX_BUFFER);

   always_comb begin
      mapped = 1'b1;
      rdVal  = 8'h00;
      case (regIdx)
         `SSP_IDX_INT_CTL:   rdVal = intCtl;
         `SSP_IDX_IRQ_FLAGS: rdVal = irqFlags;
         `SSP_IDX_BUFFER:    rdVal = serialBuffer;
         `SSP_IDX_CONTROL:   rdVal = {wrColl, rxOvf, cfg};
         `SSP_IDX_DIR_A:     rdVal = {2'b00, dirA};
         `SSP_IDX_IRQ_EN:    rdVal = irqEn;
         `SSP_IDX_STATUS:    rdVal = {7'h00, bufFull};
         `SSP_IDX_DIR_C:     rdVal = dirC;
         default:            mapped = 1'b0;
      endcase
   end

   // One wait-free access phase: data is latched during setup
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata  <= {24'h000000, rdVal};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg    <= `SSP_RST_CONTROL;
         intCtl <= 8'h00;
         irqEn  <= 8'h00;
         dirA   <= `SSP_RST_DIR_A;
         dirC   <= `SSP_RST_DIR_C;
      end else if (wrAcc) begin
         case (regIdx)
            `SSP_IDX_CONTROL: cfg    <= pwdata[5:0];
            `SSP_IDX_INT_CTL: intCtl <= pwdata[7:0];
            `SSP_IDX_IRQ_EN:  irqEn  <= pwdata[7:0];
            `SSP_IDX_DIR_A:   dirA   <= pwdata[5:0];
            `SSP_IDX_DIR_C:   dirC   <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Hardware sets win over a software clear in the same cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wrColl       <= 1'b0;
         rxOvf        <= 1'b0;
         bufFull      <= 1'b0;
         irqFlags     <= 8'h00;
         serialBuffer <= 8'h00;
         wakeReq      <= 1'b0;
      end else begin
         if (bufWr & busy)
            wrColl <= 1'b1;
         else if (wrAcc & (regIdx == `SSP_IDX_CONTROL))
            wrColl <= wrColl & pwdata[`SSP_BIT_WCOLL];
         if (done & ~keepRx)
            rxOvf <= 1'b1;
         else if (wrAcc & (regIdx == `SSP_IDX_CONTROL))
            rxOvf <= rxOvf & pwdata[`SSP_BIT_OVF];
         if (done & keepRx) begin
            serialBuffer <= rxByte;
            bufFull      <= 1'b1;
         end else if (bufRd) begin
            bufFull <= 1'b0;
         end
         if (wrAcc & (regIdx == `SSP_IDX_IRQ_FLAGS))
            irqFlags <= pwdata[7:0];
         if (done)
            irqFlags[`SSP_BIT_FLAG] <= 1'b1;
         wakeReq <= coreSleep & irqFlags[`SSP_BIT_FLAG]
                    & irqEn[`SSP_BIT_FLAG];
      end
   end

   // First stage feeds only the second; a level counts once 2 and 3 agree
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         syn1 <= `SSP_RST_PINS;
         syn2 <= `SSP_RST_PINS;
         syn3 <= `SSP_RST_PINS;
         pinF <= `SSP_RST_PINS;
      end else begin
         syn1 <= {lnk.sck, lnk.ssN, lnk.devSdi};
         syn2 <= syn1;
         syn3 <= syn2;
         pinF <= (syn2 & syn3) | (pinF & (syn2 ^ syn3));
      end
   end

   // Master clock stops in sleep; slave keeps running off the pin clock
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state    <= ST_OFF;
         shiftReg <= 8'h00;
         bitCnt   <= 4'h0;
         divCnt   <= 6'h00;
         sckInt   <= 1'b0;
         outBit   <= 1'b0;
         sckPrev  <= 1'b0;
      end else begin
         sckPrev <= pinF[2];
         divCnt  <= (mEdge | (state != ST_SHIFT)) ? 6'h00 : divCnt + 6'h01;
         case (state)
            ST_OFF: begin
               sckInt <= ckPol;
               bitCnt <= 4'h0;
               if (portEn)
                  state <= ST_IDLE;
            end
            ST_IDLE: begin
               sckInt <= ckPol;
               if (~portEn)
                  state <= ST_OFF;
               else if (master & bufWr)
                  state <= ST_SHIFT;
               else if (master & dirC[`SSP_BIT_CLK_DIR])
                  state <= ST_SHIFT;
            end
            ST_SHIFT: begin
               if (mEdge)
                  sckInt <= ~sckInt;
               if (~portEn)
                  state <= ST_OFF;
               else if (done)
                  state <= ST_IDLE;
            end
            default: state <= ST_OFF;
         endcase
         if (bufWr & ~busy) begin
            shiftReg <= pwdata[7:0];
            outBit   <= pwdata[7];
         end else begin
            if (lead)
               outBit <= shiftReg[7];
            if (trail) begin
               shiftReg <= rxByte;
               bitCnt   <= done ? 4'h0 : bitCnt + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lnk.devSckO  <= 1'b0;
         lnk.devSckOe <= 1'b0;
         lnk.devSdo   <= 1'b0;
         lnk.devSdoOe <= 1'b0;
      end else begin
         lnk.devSckO  <= (state == ST_SHIFT) ? sckInt : ckPol;
         lnk.devSckOe <= master & ~dirC[`SSP_BIT_CLK_DIR];
         lnk.devSdo   <= outBit;
         lnk.devSdoOe <= (master | slave) & ~dirC[`SSP_BIT_DOUT_DIR]
                         & ssOk;
      end
   end
endmodule
`default_nettype wire

// file: rtl/ssp_defs.svh
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// Port register indices; byte address is four times the index
`define SSP_IDX_INT_CTL    8'h0B
`define SSP_IDX_IRQ_FLAGS  8'h0C
`define SSP_IDX_BUFFER     8'h13
`define SSP_IDX_CONTROL    8'h14
`define SSP_IDX_DIR_A      8'h85
`define SSP_IDX_IRQ_EN     8'h8C
`define SSP_IDX_STATUS     8'h94
`define SSP_IDX_DIR_C      8'h87

// Reset values
`define SSP_RST_CONTROL    6'h00
`define SSP_RST_DIR_A      6'h3F
`define SSP_RST_DIR_C      8'hFF
`define SSP_RST_PINS       3'h3

// Field positions
`define SSP_BIT_FLAG       3
`define SSP_BIT_WCOLL      7
`define SSP_BIT_OVF        6
`define SSP_BIT_EN         5
`define SSP_BIT_CKPOL      4
`define SSP_BIT_SEL_DIR    5
`define SSP_BIT_CLK_DIR    3
`define SSP_BIT_DIN_DIR    4
`define SSP_BIT_DOUT_DIR   5

// Mode field encodings
`define SSP_MODE_TIMER     4'h3
`define SSP_MODE_SLV_SEL   4'h4
`define SSP_MODE_SLV       4'h5

// Serial clock half periods in core clocks (4, 16, 64 per bit)
`define SSP_HALF_DIV4      6'h02
`define SSP_HALF_DIV16     6'h08
`define SSP_HALF_DIV64     6'h20

// Partner register indices and reset values
`define SSP_P_IDX_CTRL     8'h00
`define SSP_P_IDX_DATA     8'h01
`define SSP_P_IDX_STAT     8'h02
`define SSP_P_IDX_SEL      8'h03
`define SSP_P_RST_CTRL     16'h2000

`endif

// file: rtl/ssp_pkg.sv
package ssp_pkg;
   typedef enum logic [2:0] {
      ST_OFF   = 3'b001,
      ST_IDLE  = 3'b010,
      ST_SHIFT = 3'b100
   } ssp_state_t;
endpackage

// file: rtl/ssp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssp_link_if;
   logic devSckO;
   logic devSckOe;
   logic devSdo;
   logic devSdoOe;
   logic ptnSckO;
   logic ptnSckOe;
   logic ptnSdo;
   logic ptnSdoOe;
   logic ptnSsN;
   logic sck;
   logic devSdi;
   logic ptnSdi;
   logic ssN;

   // Weak pull-down on the clock, pull-ups on undriven data lines
   assign sck    = devSckOe ? devSckO : (ptnSckOe ? ptnSckO : 1'b0);
   assign devSdi = ptnSdoOe ? ptnSdo : 1'b1;
   assign ptnSdi = devSdoOe ? devSdo : 1'b1;
   assign ssN    = ptnSsN;

   modport dev (output devSckO, devSckOe, devSdo, devSdoOe,
                input  sck, devSdi, ssN);
   modport ptn (output ptnSckO, ptnSckOe, ptnSdo, ptnSdoOe, ptnSsN,
                input  sck, ptnSdi);
endinterface
`default_nettype wire

// file: rtl/ssp_partner.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defs.svh"
module ssp_partner
   import ssp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [9:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   ssp_link_if.ptn          lnk
);
   logic [15:0] ctrl;
   logic        selN;
   logic        doneFlag;
   logic        sckInt;
   logic        outBit;
   logic        sckPrev;
   logic [7:0]  shiftReg;
   logic [7:0]  rxData;
   logic [3:0]  bitCnt;
   logic [7:0]  divCnt;
   logic [1:0]  syn1;
   logic [1:0]  syn2;
   logic [1:0]  syn3;
   logic [1:0]  pinF;
   ssp_state_t  state;
   logic [7:0]  regIdx;
   logic        acc;
   logic        wrAcc;
   logic        en;
   logic        slv;
   logic        cpol;
   logic        mEdge;
   logic        lead;
   logic        trail;
   logic        done;
   logic        busy;
   logic        start;
   logic        mapped;
   logic [15:0] rdVal;

   assign regIdx = paddr[9:2];
   assign acc    = psel & penable & pready;
   assign wrAcc  = acc & pwrite & mapped;
   assign en     = ctrl[0];
   assign slv    = ctrl[1];
   assign cpol   = ctrl[2];
   assign mEdge  = en & ~slv & (state == ST_SHIFT)
                   & (divCnt == ctrl[15:8] - 8'h01);
   assign lead   = slv ? (en & (pinF[1] != sckPrev) & (pinF[1] != cpol))
                       : (mEdge & (sckInt == cpol));
   assign trail  = slv ? (en & (pinF[1] != sckPrev) & (pinF[1] == cpol))
                       : (mEdge & (sckInt != cpol));
   assign done   = trail & (bitCnt == 4'h7);
   assign busy   = (state == ST_SHIFT) | (slv & (bitCnt != 4'h0));
   assign start  = wrAcc & (regIdx == `SSP_P_IDX_DATA) & ~busy & en;

   always_comb begin
      mapped = 1'b1;
      rdVal  = 16'h0000;
      case (regIdx)
         `SSP_P_IDX_CTRL: rdVal = ctrl;
         `SSP_P_IDX_DATA: rdVal = {8'h00, rxData};
         `SSP_P_IDX_STAT: rdVal = {14'h0000, doneFlag, busy};
         `SSP_P_IDX_SEL:  rdVal = {15'h0000, selN};
         default:         mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata  <= {16'h0000, rdVal};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl     <= `SSP_P_RST_CTRL;
         selN     <= 1'b1;
         doneFlag <= 1'b0;
         rxData   <= 8'h00;
      end else begin
         if (wrAcc & (regIdx == `SSP_P_IDX_CTRL))
            ctrl <= pwdata[15:0];
         if (wrAcc & (regIdx == `SSP_P_IDX_SEL))
            selN <= pwdata[0];
         if (done) begin
            doneFlag <= 1'b1;
            rxData   <= {shiftReg[6:0], pinF[0]};
         end else if (wrAcc & (regIdx == `SSP_P_IDX_STAT) & pwdata[1]) begin
            doneFlag <= 1'b0;
         end
      end
   end

   // Partner sees the device clock and data from outside its own domain
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         syn1 <= 2'h1;
         syn2 <= 2'h1;
         syn3 <= 2'h1;
         pinF <= 2'h1;
      end else begin
         syn1 <= {lnk.sck, lnk.ptnSdi};
         syn2 <= syn1;
         syn3 <= syn2;
         pinF <= (syn2 & syn3) | (pinF & (syn2 ^ syn3));
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state    <= ST_OFF;
         shiftReg <= 8'h00;
         bitCnt   <= 4'h0;
         divCnt   <= 8'h00;
         sckInt   <= 1'b0;
         outBit   <= 1'b1;
         sckPrev  <= 1'b0;
      end else begin
         sckPrev <= pinF[1];
         divCnt  <= (mEdge | (state != ST_SHIFT)) ? 8'h00 : divCnt + 8'h01;
         case (state)
            ST_OFF: begin
               sckInt <= cpol;
               bitCnt <= 4'h0;
               if (en)
                  state <= ST_IDLE;
            end
            ST_IDLE: begin
               sckInt <= cpol;
               if (~en)
                  state <= ST_OFF;
               else if (start & ~slv)
                  state <= ST_SHIFT;
            end
            ST_SHIFT: begin
               if (mEdge)
                  sckInt <= ~sckInt;
               if (~en)
                  state <= ST_OFF;
               else if (done)
                  state <= ST_IDLE;
            end
            default: state <= ST_OFF;
         endcase
         if (start) begin
            shiftReg <= pwdata[7:0];
            outBit   <= pwdata[7];
         end else begin
            if (lead)
               outBit <= shiftReg[7];
            if (trail) begin
               shiftReg <= {shiftReg[6:0], pinF[0]};
               bitCnt   <= done ? 4'h0 : bitCnt + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lnk.ptnSckO  <= 1'b0;
         lnk.ptnSckOe <= 1'b0;
         lnk.ptnSdo   <= 1'b1;
         lnk.ptnSdoOe <= 1'b0;
         lnk.ptnSsN   <= 1'b1;
      end else begin
         lnk.ptnSckO  <= sckInt;
         lnk.ptnSckOe <= en & ~slv;
         lnk.ptnSdo   <= outBit;
         lnk.ptnSdoOe <= en;
         lnk.ptnSsN   <= selN;
      end
   end
endmodule
`default_nettype wire

// file: verif/ssp_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_link_sva (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic devSckO,
   input wire logic devSckOe,
   input wire logic devSdo,
   input wire logic devSdoOe,
   input wire logic ptnSckO,
   input wire logic ptnSckOe,
   input wire logic ptnSdo,
   input wire logic ptnSdoOe,
   input wire logic ssN
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   logic       prevSck;
   logic       prevOe;
   logic       startLvl;
   logic [4:0] edgeCnt;
   logic [7:0] quiet;
   // Needs a cycle of drive first, so enabling at idle high is no edge
   wire        devEdge = devSckOe && prevOe && (devSckO != prevSck);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prevSck <= 1'b0;
         prevOe  <= 1'b0;
      end else begin
         prevSck <= devSckO;
         prevOe  <= devSckOe;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) quiet <= 8'h00;
      else if (devEdge) quiet <= 8'h00;
      else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
   end

   // A gap far longer than any half period ends a run of bytes
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) edgeCnt <= 5'h00;
      else if (devEdge) edgeCnt <= edgeCnt + 5'h01;
      else if (quiet == 8'hC9) edgeCnt <= 5'h00;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) startLvl <= 1'b0;
      else if (devEdge && edgeCnt == 5'h00) startLvl <= prevSck;
   end

   sequence sckEdge;
      devEdge;
   endsequence
   sequence longQuiet;
      quiet == 8'hC8;
   endsequence

   AST_SCK_MIN_HALF:
      assert property (sckEdge |=> !devEdge)
      else $error("device clock edges one cycle apart");
   AST_BYTE_EDGES:
      assert property (longQuiet |-> edgeCnt[3:0] == 4'h0)
      else $error("device clock stopped inside a byte");
   AST_IDLE_LEVEL:
      assert property (longQuiet ##0 (edgeCnt != 5'h00 && devSckOe)
                       |-> devSckO == startLvl)
      else $error("device clock rests off its idle level");
   AST_DESELECT_RELEASE:
      assert property ($rose(ssN) |-> ##[0:6] !devSdoOe)
      else $error("data out still driven after deselect");
   AST_DRIVE_NEEDS_SEL:
      assert property (ssN [*8] |-> !devSdoOe)
      else $error("data out driven while deselected");
   AST_SDO_HOLDS_BIT:
      assert property ($changed(devSdo) && devSdoOe && devSckOe
                       |=> $stable(devSdo))
      else $error("device data out glitches");
   AST_SLAVE_SYNC_DELAY:
      assert property (ptnSckOe && !devSckOe && $changed(ptnSckO)
                       |=> $stable(devSdo) [*2])
      else $error("device reacts to clock pin too soon");
   AST_PTN_SDO_HOLD:
      assert property ($changed(ptnSdo) && ptnSdoOe |=> $stable(ptnSdo))
      else $error("far end data out glitches");
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ssp_pkg::*;
;
   typedef struct packed {
      logic [3:0] mode;
      logic       pol;
      logic [7:0] dTx;
      logic [7:0] pTx;
      logic       chkD;
      logic       chkP;
   } ssp_row_t;
   // Fast master rates outrun the round trip: mode 0 checks neither way, mode 1 only the partner's receive
   localparam ssp_row_t ROWS [7] = '{
      '{4'h0, 1'b0, 8'hA5, 8'h3C, 1'b0, 1'b0},
      '{4'h1, 1'b1, 8'h5A, 8'hC3, 1'b0, 1'b1},
      '{4'h2, 1'b0, 8'h81, 8'h7E, 1'b1, 1'b1},
      '{4'h2, 1'b1, 8'h96, 8'h69, 1'b1, 1'b1},
      '{4'h3, 1'b0, 8'hF0, 8'h0F, 1'b1, 1'b1},
      '{4'h5, 1'b0, 8'hC5, 8'h3A, 1'b1, 1'b1},
      '{4'h5, 1'b1, 8'h12, 8'hED, 1'b1, 1'b1}};

   logic             clk = 1'b0;
   logic             sys_rst;
   logic [1:0]       apSel;
   logic [1:0]       apEn;
   logic [1:0]       apWr;
   logic [1:0][9:0]  apAddr;
   logic [1:0][31:0] apWdata;
   wire  [1:0][31:0] apRdata;
   wire  [1:0]       apRdy;
   wire  [1:0]       apErr;
   logic             timerTick = 1'b0;
   logic             coreSleep;
   wire              wakeReq;
   logic [5:0]       tickCnt = 6'h00;
   int               fails;
   int               numChecks;
   logic [31:0]      rdv;
   logic             rerr;
   ssp_row_t         r;
   logic             master;

   ssp_link_if lnk ();
   ssp_port i_ssp_port (.clk(clk), .sys_rst(sys_rst), .psel(apSel[0]),
      .penable(apEn[0]), .pwrite(apWr[0]), .paddr(apAddr[0]),
      .pwdata(apWdata[0]), .prdata(apRdata[0]), .pready(apRdy[0]),
      .pslverr(apErr[0]), .timerTick(timerTick), .coreSleep(coreSleep),
      .wakeReq(wakeReq), .lnk(lnk));
   ssp_partner i_ssp_partner (.clk(clk), .sys_rst(sys_rst),
      .psel(apSel[1]), .penable(apEn[1]), .pwrite(apWr[1]),
      .paddr(apAddr[1]), .pwdata(apWdata[1]), .prdata(apRdata[1]),
      .pready(apRdy[1]), .pslverr(apErr[1]), .lnk(lnk));
   ssp_link_sva i_ssp_link_sva (.clk(clk), .sys_rst(sys_rst),
      .devSckO(lnk.devSckO), .devSckOe(lnk.devSckOe),
      .devSdo(lnk.devSdo), .devSdoOe(lnk.devSdoOe),
      .ptnSckO(lnk.ptnSckO), .ptnSckOe(lnk.ptnSckOe),
      .ptnSdo(lnk.ptnSdo), .ptnSdoOe(lnk.ptnSdoOe), .ssN(lnk.ssN));

   always #2.5 clk = ~clk;

   always @(posedge clk) begin
      tickCnt <= (tickCnt == 6'h27) ? 6'h00 : tickCnt + 6'h01;
      timerTick <= (tickCnt == 6'h27);
   end

   task cmp(input logic [32:0] got, input logic [32:0] exp);
      numChecks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task apb(input int w, input logic wr, input logic [7:0] idx,
            input logic [31:0] wd);
      @(posedge clk);
      apSel[w] <= 1'b1;
      apWr[w] <= wr;
      apAddr[w] <= {idx, 2'b00};
      apWdata[w] <= wd;
      @(posedge clk);
      apEn[w] <= 1'b1;
      // Read at the edge itself, before that edge's updates land
      do begin
         @(posedge clk);
      end while (apRdy[w] !== 1'b1);
      rdv = apRdata[w];
      rerr = apErr[w];
      apSel[w] <= 1'b0;
      apEn[w] <= 1'b0;
   endtask

   task ptnCfg(input logic p, input logic m);
      wr(1, 8'h00, 32'h0);
      wr(1, 8'h00, 32'h1001 | {29'h0, p, m, 1'b0});
   endtask

   task wr(input int w, input logic [7:0] idx, input logic [31:0] d);
      apb(w, 1'b1, idx, d);
   endtask

   task chk(input int w, input logic [7:0] idx, input logic [31:0] exp,
            input logic e = 1'b0);
      apb(w, 1'b0, idx, 32'h0);
      cmp({rerr, rdv}, {e, exp});
   endtask

   task waitSet(input int w, input logic [7:0] idx, input logic [31:0] m);
      int k;
      k = 0;
      do begin
         apb(w, 1'b0, idx, 32'h0);
         k++;
      end while ((rdv & m) == 32'h0 && k < 400);
      cmp({32'h0, |(rdv & m)}, 33'h1);
   endtask

   task cfgDev(input logic [7:0] ctl, input logic [7:0] dirc);
      wr(0, 8'h14, 32'h0);
      wr(0, 8'h87, {24'h0, dirc});
      wr(0, 8'h14, {24'h0, ctl});
   endtask

   task test_done;
      $display("checks %0d mismatches %0d", numChecks, fails);
      if (fails == 0 && numChecks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      test_done;
   end

   initial begin
      sys_rst = 1'b1;
      {apSel, apEn, apWr, apAddr, apWdata} = '0;
      {coreSleep, fails, numChecks} = '0;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      wr(1, 8'h03, 32'h0);
      foreach (ROWS[i]) begin
         r = ROWS[i];
         master = (r.mode < 4'h4);
         // Clock owner settles its idle level first: no false edge
         if (!master) ptnCfg(r.pol, master);
         cfgDev({3'b001, r.pol, r.mode}, master ? 8'hD7 : 8'hDF);
         if (master) ptnCfg(r.pol, master);
         if (master) wr(1, 8'h01, {24'h0, r.pTx});
         wr(0, 8'h13, {24'h0, r.dTx});
         if (!master) wr(1, 8'h01, {24'h0, r.pTx});
         waitSet(0, 8'h94, 32'h1);
         if (r.chkP) waitSet(1, 8'h02, 32'h2);
         apb(0, 1'b0, 8'h13, 32'h0);
         if (r.chkD) cmp({rerr, rdv}, {25'h0, r.pTx});
         chk(0, 8'h94, 32'h0);
         chk(0, 8'h0C, 32'h08);
         wr(0, 8'h0C, 32'h0);
         if (r.chkP) chk(1, 8'h01, {24'h0, r.dTx});
         wr(1, 8'h02, 32'h2);
         $display("row %0d done", i);
      end

      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      chk(0, 8'h14, 32'h0);
      chk(0, 8'h85, 32'h3F);
      chk(0, 8'h0C, 32'h0);
      chk(0, 8'h8C, 32'h0);
      chk(1, 8'h00, 32'h2000);
      wr(0, 8'h94, 32'hFF);
      chk(0, 8'h94, 32'h0);
      chk(0, 8'h50, 32'h0, 1'b1);
      cmp({32'h0, wakeReq}, 33'h0);
      wr(1, 8'h03, 32'h0);
      $display("reset test done");

      wr(1, 8'h00, 32'h1003);
      cfgDev(8'h22, 8'hD7);
      wr(1, 8'h01, 32'h0);
      wr(0, 8'h13, 32'h4D);
      wr(0, 8'h13, 32'hB2);
      chk(0, 8'h14, 32'hA2);
      waitSet(1, 8'h02, 32'h2);
      chk(1, 8'h01, 32'h4D);
      apb(0, 1'b0, 8'h13, 32'h0);
      wr(0, 8'h14, 32'h22);
      chk(0, 8'h14, 32'h22);
      {rdv, rerr} = '0;
      wr(0, 8'h0C, 32'h0);
      wr(1, 8'h02, 32'h2);
      $display("collision test done");

      cfgDev(8'h25, 8'hDF);
      wr(1, 8'h00, 32'h0);
      wr(1, 8'h00, 32'h1001);
      wr(1, 8'h01, 32'h11);
      waitSet(0, 8'h94, 32'h1);
      wr(1, 8'h02, 32'h2);
      wr(1, 8'h01, 32'h22);
      waitSet(0, 8'h14, 32'h40);
      chk(0, 8'h13, 32'h11);
      chk(0, 8'h0C, 32'h08);
      wr(0, 8'h14, 32'h25);
      wr(0, 8'h0C, 32'h0);
      wr(1, 8'h02, 32'h2);
      $display("overflow test done");

      cfgDev(8'h24, 8'hDF);
      wr(1, 8'h03, 32'h1);
      wr(1, 8'h01, 32'h77);
      waitSet(1, 8'h02, 32'h2);
      repeat (8) @(posedge clk);
      chk(0, 8'h94, 32'h0);
      wr(1, 8'h02, 32'h2);
      wr(1, 8'h03, 32'h0);
      wr(1, 8'h01, 32'h5C);
      waitSet(0, 8'h94, 32'h1);
      chk(0, 8'h13, 32'h5C);
      waitSet(1, 8'h02, 32'h2);
      wr(1, 8'h02, 32'h2);
      wr(1, 8'h01, 32'hAA);
      // Deselect lands a few bits into the byte
      repeat (100) @(posedge clk);
      wr(1, 8'h03, 32'h1);
      waitSet(1, 8'h02, 32'h2);
      chk(0, 8'h94, 32'h0);
      wr(1, 8'h02, 32'h2);
      $display("select test done");

      wr(1, 8'h03, 32'h0);
      cfgDev(8'h25, 8'hFF);
      wr(0, 8'h8C, 32'h08);
      wr(0, 8'h13, 32'h0);
      @(posedge clk);
      coreSleep <= 1'b1;
      wr(1, 8'h01, 32'h3E);
      waitSet(0, 8'h0C, 32'h08);
      cmp({32'h0, wakeReq}, 33'h1);
      @(posedge clk);
      coreSleep <= 1'b0;
      waitSet(1, 8'h02, 32'h2);
      chk(1, 8'h01, 32'hFF);
      chk(0, 8'h13, 32'h3E);
      wr(0, 8'h0C, 32'h0);
      $display("sleep test done");

      wr(1, 8'h00, 32'h0);
      cfgDev(8'h22, 8'hDF);
      waitSet(0, 8'h94, 32'h1);
      chk(0, 8'h13, 32'hFF);
      $display("monitor test done");
      test_done;
   end
endmodule
`default_nettype wire
